// File: hw/acfc_codec.sv
// application frame codec top: receive decode, auto answer, transmit sequencing
`include "acfc_regs.svh"
module acfc_codec (
   input wire logic clock, // 100 MHz system clock
   input wire logic rst_n, // asynchronous reset, active low
   input wire logic [6:0] node_addr, // own address, static
   // frame from controller
   input wire logic rx_valid, // one-cycle: frame received
   input wire logic [10:0] rx_id, // received identifier
   input wire logic rx_rtr, // received request bit
   input wire logic [3:0] rx_len, // received length code
   input wire logic [63:0] rx_data, // received data, byte 1 high
   // frame to controller
   output logic tx_valid_reg, // level: frame offered
   input wire logic tx_ready, // controller takes frame
   output logic [10:0] tx_id_reg, // sent identifier
   output logic tx_rtr_reg, // sent request bit
   output logic [3:0] tx_len_reg, // sent length code
   output logic [63:0] tx_data_reg, // sent data
   // application: send request
   input wire logic app_req, // one-cycle send request
   output logic app_busy_reg, // sequencer busy, requests ignored
   input wire logic app_short, // short form
   input wire logic app_dir, // direction/priority
   input wire logic [6:0] app_addr, // logical address
   input wire logic [2:0] app_svc, // service type
   input wire logic [1:0] app_class, // message class
   input wire logic app_frag, // fragmentation flag
   input wire logic [4:0] app_sel, // object selector
   input wire logic [3:0] app_len, // length code
   input wire logic [55:0] app_params, // bytes 2..8
   output logic app_error_reg, // one-cycle: request refused
   // application: long request answer
   input wire logic ans_req, // one-cycle answer to last request
   input wire logic ans_fail, // answer with error response
   input wire logic [7:0] ans_code, // error code byte
   // application: received frame
   output logic rx_hit_reg, // one-cycle: accepted frame
   output logic rx_malformed_reg, // one-cycle: malformed frame
   output logic rx_short_reg, // accepted frame short form
   output logic rx_dir_reg, // direction bit
   output logic [2:0] rx_svc_reg, // service type
   output logic [1:0] rx_class_reg, // message class
   output logic rx_frag_reg, // fragmentation flag
   output logic [4:0] rx_sel_reg, // object selector
   output logic [3:0] rx_len_reg, // length code
   output logic [55:0] rx_param_reg, // parameter bytes
   output logic state_reg // single binary object state
);
   // ----------------------------------------
   // reset synchroniser
   // ----------------------------------------
   logic rst_meta_reg;
   logic rst_sync_reg;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_reg <= 1'b0;
         rst_sync_reg <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_sync_reg <= rst_meta_reg;
      end
   end

   // ----------------------------------------
   // receive path
   // ----------------------------------------
   logic dec_hit;
   logic dec_short;
   logic dec_bad;
   logic dec_dir;
   logic [2:0] dec_svc;
   logic [1:0] dec_class;
   logic dec_frag;
   logic [4:0] dec_sel;
   logic [3:0] dec_len;
   logic [55:0] dec_param;

   acfc_rx_decoder u_dec (
      .clock(clock),
      .rst_n(rst_sync_reg),
      .frame_valid(rx_valid),
      .frame_id(rx_id),
      .frame_rtr(rx_rtr),
      .frame_len(rx_len),
      .frame_data(rx_data),
      .node_addr(node_addr),
      .hit_reg(dec_hit),
      .short_reg(dec_short),
      .malformed_reg(dec_bad),
      .dir_reg(dec_dir),
      .svc_reg(dec_svc),
      .class_reg(dec_class),
      .fragment_flag_reg(dec_frag),
      .object_selector_reg(dec_sel),
      .len_reg(dec_len),
      .param_reg(dec_param)
   );

   // short set commands addressed to us
   wire cmd_off = dec_hit && dec_short && !dec_dir
      && (dec_svc == acfc_pkg::set_off_command);
   wire cmd_on = dec_hit && dec_short && !dec_dir
      && (dec_svc == acfc_pkg::set_on_command);
   // long requests wait for the application's answer
   wire long_req = dec_hit && !dec_short && (dec_class == acfc_pkg::class_request);

   // ----------------------------------------
   // pending answers
   // ----------------------------------------
   // a short command acknowledge is owed; set wins over the clear by the sequencer
   logic ack_pend_reg;
   logic [2:0] ack_svc_reg;
   logic ans_pend_reg;
   logic ans_fail_reg;
   logic [7:0] ans_code_reg;
   logic [2:0] req_svc_reg;
   logic [4:0] req_sel_reg;
   logic pend_taken;
   logic ans_taken;

   // command execution and acknowledge bookkeeping
   always_ff @(posedge clock or negedge rst_sync_reg) begin
      if (!rst_sync_reg) begin
         state_reg <= 1'b0;
         ack_pend_reg <= 1'b0;
         ack_svc_reg <= 3'h0;
      end else begin
         if (cmd_off || cmd_on) begin
            state_reg <= cmd_on;
            ack_pend_reg <= 1'b1;
            ack_svc_reg <= cmd_on ? acfc_pkg::set_on_acknowledge
                                  : acfc_pkg::set_off_acknowledge;
         end else if (pend_taken) begin
            ack_pend_reg <= 1'b0;
         end
      end
   end

   // long request context and answer capture
   always_ff @(posedge clock or negedge rst_sync_reg) begin
      if (!rst_sync_reg) begin
         req_svc_reg <= 3'h0;
         req_sel_reg <= 5'h00;
         ans_pend_reg <= 1'b0;
         ans_fail_reg <= 1'b0;
         ans_code_reg <= `ACFC_RESET_BYTE;
      end else begin
         if (long_req) begin
            req_svc_reg <= dec_svc;
            req_sel_reg <= dec_sel;
         end
         if (ans_req) begin
            ans_pend_reg <= 1'b1;
            ans_fail_reg <= ans_fail;
            ans_code_reg <= ans_code;
         end else if (ans_taken) begin
            ans_pend_reg <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // transmit sequencer
   // ----------------------------------------
   acfc_pkg::acfc_tx_state_type tx_state_reg;
   acfc_pkg::acfc_tx_state_type tx_state_next;
   logic enc_error;
   logic [10:0] enc_id;
   logic enc_rtr;
   logic [3:0] enc_len;
   logic [63:0] enc_data;

   // source select: short ack first, then long answer, then application
   wire idle = tx_state_reg == acfc_pkg::tx_idle;
   wire pick_ack = idle && ack_pend_reg;
   wire pick_ans = idle && !ack_pend_reg && ans_pend_reg;
   wire pick_app = idle && !ack_pend_reg && !ans_pend_reg && app_req;
   assign pend_taken = pick_ack;
   assign ans_taken = pick_ans;
   wire enc_load = pick_ack || pick_ans || pick_app;
   // answers carry our own address as source
   wire sel_dir = pick_app ? app_dir : 1'b1;
   wire [6:0] sel_addr = pick_app ? app_addr : node_addr;
   // single object acks in short form
   wire sel_short = pick_app ? app_short : pick_ack;
   wire [2:0] sel_svc = pick_ack ? ack_svc_reg : (pick_ans ? req_svc_reg : app_svc);
   // success toward initiator; error with code byte
   wire [1:0] sel_class = pick_app ? app_class
      : (ans_fail_reg ? acfc_pkg::class_error : acfc_pkg::class_success);
   wire sel_frag = pick_app && app_frag;
   wire [4:0] sel_sel = pick_app ? app_sel : req_sel_reg;
   wire [3:0] sel_len = pick_app ? app_len : `ACFC_LEN_MIN;
   wire [55:0] sel_params = pick_app ? app_params
      : (ans_fail_reg ? {ans_code_reg, 48'h0000_0000_0000} : 56'h00_0000_0000_0000);

   acfc_tx_encoder u_enc (
      .clock(clock),
      .rst_n(rst_sync_reg),
      .load(enc_load),
      .dir(sel_dir),
      .addr(sel_addr),
      .svc(sel_svc),
      .is_short(sel_short),
      .msg_class(sel_class),
      .frag(sel_frag),
      .sel(sel_sel),
      .len(sel_len),
      .params(sel_params),
      .id_reg(enc_id),
      .rtr_reg(enc_rtr),
      .len_reg(enc_len),
      .data_reg(enc_data),
      .error_reg(enc_error)
   );

   // next state: send waits one cycle for the encoder register
   always_comb begin
      tx_state_next = tx_state_reg;
      case (tx_state_reg)
         acfc_pkg::tx_idle: if (enc_load) tx_state_next = acfc_pkg::tx_send;
         acfc_pkg::tx_send: tx_state_next = enc_error ? acfc_pkg::tx_idle : acfc_pkg::tx_wait;
         acfc_pkg::tx_wait: if (tx_ready) tx_state_next = acfc_pkg::tx_idle;
         default: tx_state_next = acfc_pkg::tx_idle;
      endcase
   end

   // sequencer state
   always_ff @(posedge clock or negedge rst_sync_reg) begin
      if (!rst_sync_reg) tx_state_reg <= acfc_pkg::tx_idle;
      else tx_state_reg <= tx_state_next;
   end

   // ----------------------------------------
   // output registers
   // ----------------------------------------
   // frame registers load once the encoder holds a good frame
   wire offer = (tx_state_reg == acfc_pkg::tx_send) && !enc_error;
   always_ff @(posedge clock or negedge rst_sync_reg) begin
      if (!rst_sync_reg) begin
         tx_valid_reg <= 1'b0;
         tx_id_reg <= 11'h000;
         tx_rtr_reg <= 1'b0;
         tx_len_reg <= 4'h0;
         tx_data_reg <= 64'h0000_0000_0000_0000;
      end else begin
         if (offer) begin
            tx_valid_reg <= 1'b1;
            tx_id_reg <= enc_id;
            // request bit from encoder is always low
            tx_rtr_reg <= enc_rtr;
            tx_len_reg <= enc_len;
            tx_data_reg <= enc_data;
         end else if (tx_valid_reg && tx_ready) begin
            tx_valid_reg <= 1'b0;
         end
      end
   end

   // status and receive outputs
   always_ff @(posedge clock or negedge rst_sync_reg) begin
      if (!rst_sync_reg) begin
         app_busy_reg <= 1'b0;
         app_error_reg <= 1'b0;
         rx_hit_reg <= 1'b0;
         rx_malformed_reg <= 1'b0;
         rx_short_reg <= 1'b0;
         rx_dir_reg <= 1'b0;
         rx_svc_reg <= 3'h0;
         rx_class_reg <= 2'h0;
         rx_frag_reg <= 1'b0;
         rx_sel_reg <= 5'h00;
         rx_len_reg <= 4'h0;
         rx_param_reg <= 56'h00_0000_0000_0000;
      end else begin
         app_busy_reg <= (tx_state_next != acfc_pkg::tx_idle) || ack_pend_reg || ans_pend_reg;
         app_error_reg <= enc_error;
         rx_hit_reg <= dec_hit;
         rx_malformed_reg <= dec_bad;
         rx_short_reg <= dec_short;
         rx_dir_reg <= dec_dir;
         rx_svc_reg <= dec_svc;
         rx_class_reg <= dec_class;
         rx_frag_reg <= dec_frag;
         rx_sel_reg <= dec_sel;
         rx_len_reg <= dec_len;
         rx_param_reg <= dec_param;
      end
   end
endmodule

// File: shared/acfc_regs.svh
// constants for the application frame codec: field positions, codes and limits
`ifndef ACFC_REGS_SVH
`define ACFC_REGS_SVH

// identifier field positions
`define ACFC_ID_DIR_BIT 10
`define ACFC_ID_ADDR_HI 9
`define ACFC_ID_ADDR_LO 3
`define ACFC_ID_SVC_HI 2
`define ACFC_ID_SVC_LO 0
// first data byte field positions
`define ACFC_SPEC_CLASS_HI 7
`define ACFC_SPEC_CLASS_LO 6
`define ACFC_SPEC_FRAG_BIT 5
`define ACFC_SEL_HI 4
`define ACFC_SEL_LO 0
// limits
`define ACFC_ADDR_MAX 7'h7d
`define ACFC_LEN_MIN 4'h2
`define ACFC_LEN_MAX 4'h8
`define ACFC_SHORT_LEN 4'h0
`define ACFC_LONG_SVC_MIN 3'h4
`define ACFC_CLASS_RESERVED 2'h3
// reset values
`define ACFC_RESET_ADDR 7'h00
`define ACFC_RESET_BYTE 8'h00

`endif

// File: shared/acfc_pkg.sv
// types for the application frame codec
package acfc_pkg;
   // short-form service types
   typedef enum logic [2:0] {
      state_off_report = 3'h0,
      state_on_report = 3'h1,
      off_report_acknowledge = 3'h2,
      on_report_acknowledge = 3'h3,
      set_off_command = 3'h4,
      set_on_command = 3'h5,
      set_off_acknowledge = 3'h6,
      set_on_acknowledge = 3'h7
   } acfc_short_svc_type;
   // long-form service types
   typedef enum logic [2:0] {
      svc_write = 3'h4,
      svc_read = 3'h5,
      svc_action = 3'h6,
      svc_event = 3'h7
   } acfc_long_svc_type;
   // message class
   typedef enum logic [1:0] {
      class_request = 2'h0,
      class_success = 2'h1,
      class_error = 2'h2,
      class_reserved = 2'h3
   } acfc_class_type;
   // transmit sequencer states, one-hot
   typedef enum logic [2:0] {
      tx_idle = 3'b001,
      tx_send = 3'b010,
      tx_wait = 3'b100
   } acfc_tx_state_type;
endpackage

// File: hw/acfc_rx_decoder.sv
// received frame classifier and field splitter
`include "acfc_regs.svh"
module acfc_rx_decoder (
   input wire logic clock, // system clock
   input wire logic rst_n, // synchronised reset, active low
   input wire logic frame_valid, // one-cycle strobe, frame present
   input wire logic [10:0] frame_id, // received identifier
   input wire logic frame_rtr, // received request bit
   input wire logic [3:0] frame_len, // received length code
   input wire logic [63:0] frame_data, // data bytes, byte 1 in bits 63:56
   input wire logic [6:0] node_addr, // own node address
   output logic hit_reg, // one-cycle: accepted frame
   output logic short_reg, // frame was short form
   output logic malformed_reg, // one-cycle: addressed but malformed
   output logic dir_reg, // direction/priority bit
   output logic [2:0] svc_reg, // service type
   output logic [1:0] class_reg, // message class
   output logic fragment_flag_reg, // fragmentation flag
   output logic [4:0] object_selector_reg, // object selector
   output logic [3:0] len_reg, // length code
   output logic [55:0] param_reg // bytes 2..8
);
   wire [6:0] rx_addr = frame_id[`ACFC_ID_ADDR_HI:`ACFC_ID_ADDR_LO];
   wire [2:0] rx_svc = frame_id[`ACFC_ID_SVC_HI:`ACFC_ID_SVC_LO];
   wire [7:0] byte1 = frame_data[63:56];
   wire is_long = frame_len != `ACFC_SHORT_LEN;
   wire addr_match = rx_addr == node_addr;
   wire bad_long = is_long && ((rx_svc < `ACFC_LONG_SVC_MIN)
      || (byte1[7:6] == `ACFC_CLASS_RESERVED)
      || (frame_len < `ACFC_LEN_MIN) || (frame_len > `ACFC_LEN_MAX));
   // request bit set is not a valid frame
   wire bad = bad_long || frame_rtr;
   wire take = frame_valid && addr_match;

   // one-cycle strobes; fields held until next addressed frame, malformed or not
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         hit_reg <= 1'b0;
         malformed_reg <= 1'b0;
      end else begin
         hit_reg <= take && !bad;
         malformed_reg <= take && bad;
      end
   end

   // field capture
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         short_reg <= 1'b0;
         dir_reg <= 1'b0;
         svc_reg <= 3'h0;
         class_reg <= 2'h0;
         fragment_flag_reg <= 1'b0;
         object_selector_reg <= 5'h00;
         len_reg <= 4'h0;
         param_reg <= 56'h00_0000_0000_0000;
      end else if (take) begin
         short_reg <= !is_long;
         dir_reg <= frame_id[`ACFC_ID_DIR_BIT];
         svc_reg <= rx_svc;
         class_reg <= is_long ? byte1[`ACFC_SPEC_CLASS_HI:`ACFC_SPEC_CLASS_LO] : 2'h0;
         fragment_flag_reg <= is_long && byte1[`ACFC_SPEC_FRAG_BIT];
         object_selector_reg <= is_long ? byte1[`ACFC_SEL_HI:`ACFC_SEL_LO] : 5'h00;
         len_reg <= frame_len;
         param_reg <= frame_data[55:0];
      end
   end
endmodule

// File: hw/acfc_tx_encoder.sv
// transmit frame builder, one registered frame at a time
`include "acfc_regs.svh"
module acfc_tx_encoder (
   input wire logic clock, // system clock
   input wire logic rst_n, // synchronised reset, active low
   input wire logic load, // one-cycle: build frame
   input wire logic dir, // direction/priority
   input wire logic [6:0] addr, // logical address
   input wire logic [2:0] svc, // service type
   input wire logic is_short, // short form
   input wire logic [1:0] msg_class, // message class
   input wire logic frag, // fragmentation flag
   input wire logic [4:0] sel, // object selector
   input wire logic [3:0] len, // requested length code
   input wire logic [55:0] params, // bytes 2..8
   output logic [10:0] id_reg, // identifier
   output logic rtr_reg, // request bit, always 0
   output logic [3:0] len_reg, // length code
   output logic [63:0] data_reg, // data bytes
   output logic error_reg // one-cycle: request refused
);
   function automatic logic [3:0] fix_len(input logic [3:0] l);
      if (l < `ACFC_LEN_MIN) fix_len = `ACFC_LEN_MIN;
      else if (l > `ACFC_LEN_MAX) fix_len = `ACFC_LEN_MAX;
      else fix_len = l;
   endfunction

   // byte mask so unsent bytes stay zero
   function automatic logic [63:0] keep_bytes(input logic [63:0] d, input logic [3:0] l);
      logic [63:0] m;
      m = 64'h0000_0000_0000_0000;
      for (int i = 0; i < 8; i++) begin
         if (4'(i) < l) m[63-8*i -: 8] = 8'hff;
      end
      keep_bytes = d & m;
   endfunction

   wire [3:0] long_len = fix_len(len);
   // reserved long types and classes refused
   wire refuse = !is_short && ((svc < `ACFC_LONG_SVC_MIN) || (msg_class == `ACFC_CLASS_RESERVED)
      || (addr > `ACFC_ADDR_MAX));
   // short form also refuses illegal addresses
   wire refuse_all = refuse || (is_short && (addr > `ACFC_ADDR_MAX));
   wire [10:0] id_next = {dir, addr, svc};
   wire [7:0] byte1 = {msg_class, frag, sel};
   wire [63:0] data_next = is_short ? 64'h0000_0000_0000_0000
                                    : keep_bytes({byte1, params}, long_len);

   // registered frame
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         id_reg <= 11'h000;
         rtr_reg <= 1'b0;
         len_reg <= 4'h0;
         data_reg <= 64'h0000_0000_0000_0000;
         error_reg <= 1'b0;
      end else begin
         error_reg <= load && refuse_all;
         if (load && !refuse_all) begin
            id_reg <= id_next;
            rtr_reg <= 1'b0;
            // short form length zero; length equals bytes sent
            len_reg <= is_short ? `ACFC_SHORT_LEN : long_len;
            data_reg <= data_next;
         end
      end
   end
endmodule

// File: bench/acfc_ctl_model.sv
// controller stand-in: takes each offered frame after a stall of varying length
module acfc_ctl_model (
   input wire logic clock, // clock
   input wire logic rst_n, // reset
   input wire logic tx_valid_reg, // frame offered
   output logic tx_ready // frame taken
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] stall_reg;
   // lfsr bit mixes prompt and slow takes; never ready outside an offer
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         stall_reg <= 4'h5;
         tx_ready <= 1'b0;
      end else begin
         stall_reg <= {stall_reg[2:0], stall_reg[3] ^ stall_reg[2]};
         tx_ready <= tx_valid_reg && !tx_ready && stall_reg[0];
      end
   end
endmodule

// File: bench/acfc_codec_asserts.sv
// concurrent checks on the codec top ports
module acfc_codec_asserts (
   input wire logic clock, // clock
   input wire logic rst_n, // reset
   input wire logic [6:0] node_addr, // own address
   input wire logic rx_valid, // frame in
   input wire logic [10:0] rx_id, // id in
   input wire logic rx_rtr, // rtr in
   input wire logic [3:0] rx_len, // length in
   input wire logic tx_valid_reg, // frame out
   input wire logic [10:0] tx_id_reg, // id out
   input wire logic tx_rtr_reg, // rtr out
   input wire logic [3:0] tx_len_reg, // length out
   input wire logic [63:0] tx_data_reg, // data out
   input wire logic rx_hit_reg, // accepted
   input wire logic rx_malformed_reg, // refused
   input wire logic state_reg // object state
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clock);
   endclocking
   default disable iff (!rst_n);
   // own frames, short set commands, and frames that must be refused
   sequence s_mine; rx_valid && rx_id[9:3] == node_addr; endsequence
   sequence s_set;
      s_mine ##0 (!rx_rtr && rx_len == 4'h0 && rx_id[10:1] == {1'b0, node_addr, 2'b10});
   endsequence
   sequence s_bad;
      s_mine ##0 (rx_rtr || (rx_len != 4'h0
         && (!rx_id[2] || rx_len < 4'h2 || rx_len > 4'h8)));
   endsequence
   // outgoing frame shape; decode answer lands two cycles after the frame
   property p_rtr; tx_valid_reg |-> !tx_rtr_reg; endproperty
   property p_tail; tx_valid_reg |-> (tx_data_reg << {tx_len_reg, 3'b000}) == 64'h0; endproperty
   property p_long;
      tx_valid_reg && tx_len_reg != 4'h0 |-> tx_len_reg inside {[2:8]} && tx_id_reg[2];
   endproperty
   property p_class;
      tx_valid_reg && tx_len_reg != 4'h0 |-> tx_data_reg[63:62] != 2'b11;
   endproperty
   property p_addr; tx_valid_reg |-> tx_id_reg[9:3] <= 7'h7d; endproperty
   property p_set; s_set |-> ##2 rx_hit_reg && state_reg == $past(rx_id[0], 2); endproperty
   property p_bad; s_bad |-> ##2 rx_malformed_reg && !rx_hit_reg; endproperty
   property p_other;
      rx_valid && rx_id[9:3] != node_addr |-> ##2 !rx_hit_reg && !rx_malformed_reg;
   endproperty
   a_rtr: assert property (p_rtr) else $error("rtr set on sent frame");
   a_tail: assert property (p_tail) else $error("bytes past length");
   a_long: assert property (p_long) else $error("bad long length or type");
   a_class: assert property (p_class) else $error("reserved class sent");
   a_addr: assert property (p_addr) else $error("illegal address sent");
   a_set: assert property (p_set) else $error("set command not executed");
   a_bad: assert property (p_bad) else $error("malformed not flagged");
   a_other: assert property (p_other) else $error("foreign frame taken");
endmodule
bind acfc_codec acfc_codec_asserts chk (.*);

// File: bench/acfc_codec_tb.sv
// self-checking bench for the application frame codec
module acfc_codec_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock, tx_ready, tx_valid_reg, tx_rtr_reg, app_busy_reg, app_error_reg, rx_hit_reg;
   logic rx_malformed_reg, rx_short_reg, rx_dir_reg, rx_frag_reg, state_reg;
   logic rst_n = '0, rx_valid = '0, rx_rtr = '0, app_req = '0, app_short = '0, app_dir = '0;
   logic app_frag = '0, ans_req = '0, ans_fail = '0;
   logic [6:0] node_addr = 7'h2b, app_addr = '0;
   logic [10:0] rx_id = '0, tx_id_reg;
   logic [3:0] rx_len = '0, app_len = '0, tx_len_reg, rx_len_reg;
   logic [63:0] rx_data = '0, tx_data_reg;
   logic [2:0] app_svc = '0, rx_svc_reg;
   logic [1:0] app_class = '0, rx_class_reg;
   logic [4:0] app_sel = '0, rx_sel_reg;
   logic [55:0] app_params = '0, rx_param_reg;
   logic [7:0] ans_code = '0;
   logic [15:0] lfsr_reg = 16'h0023;
   int n_mismatch = 0;
   int samples_checked = 0;
   acfc_codec dut (.*);
   acfc_ctl_model ctl (.*);
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   function automatic logic [15:0] lfsr_step(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   // long length clamps to 2..8; short frames carry none
   function automatic logic [3:0] exp_len(input logic s, input logic [3:0] n);
      return s ? 4'h0 : (n < 4'h2 ? 4'h2 : (n > 4'h8 ? 4'h8 : n));
   endfunction
   function automatic logic [63:0] exp_data(input logic [63:0] raw, input logic [3:0] n);
      return raw & ~(64'hffff_ffff_ffff_ffff >> {n, 3'b000});
   endfunction
   task automatic check(input logic [63:0] got, input logic [63:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic summarize;
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // bounded wait, sampled just after the edge so updates have landed
   task automatic until_tx(input logic lvl);
      for (int k = 0; k < 30 && tx_valid_reg !== lvl; k++) begin
         @(posedge clock);
         #1;
      end
   endtask
   task automatic take(input logic [10:0] id, input logic [3:0] n, input logic [63:0] d);
      until_tx(1'b1);
      check({tx_valid_reg, tx_rtr_reg, tx_id_reg, tx_len_reg}, {2'b10, id, n});
      check(tx_data_reg, d);
      until_tx(1'b0);
   endtask
   task automatic send(input logic s, input logic [2:0] v, input logic [1:0] c,
         input logic [6:0] a, input logic [3:0] n, input logic err);
      lfsr_reg = lfsr_step(lfsr_reg);
      @(posedge clock);
      app_req <= 1'b1;
      {app_short, app_svc, app_class, app_addr, app_len} <= {s, v, c, a, n};
      {app_dir, app_frag, app_sel} <= lfsr_reg[6:0];
      app_params <= {lfsr_reg, lfsr_reg, lfsr_reg, lfsr_reg[7:0]};
      @(posedge clock);
      app_req <= 1'b0;
      @(posedge clock);
      #1;
      check(app_error_reg, err);
      @(posedge clock);
      #1;
      check({tx_valid_reg, app_busy_reg}, {2{!err}});
      if (!err) begin
         take({app_dir, app_addr, app_svc}, exp_len(s, n), exp_data({app_class, app_frag,
            app_sel, app_params}, exp_len(s, n)));
      end
   endtask
   // hb: hit and malformed strobes stand in the second cycle after the frame
   task automatic rx(input logic [10:0] id, input logic [3:0] n, input logic r,
         input logic [63:0] d, input logic [1:0] hb);
      @(posedge clock);
      {rx_valid, rx_id, rx_len, rx_rtr, rx_data} <= {1'b1, id, n, r, d};
      @(posedge clock);
      rx_valid <= 1'b0;
      rx_data <= ~d;
      @(posedge clock);
      #1;
      check({rx_hit_reg, rx_malformed_reg}, hb);
   endtask
   initial begin
      logic [63:0] d;
      logic [10:0] id;
      logic [3:0] n;
      repeat (5) @(posedge clock);
      rst_n <= 1'b1;
      repeat (3) @(posedge clock);
      for (int i = 0; i < 12; i++) begin
         send(0, 3'h4 + 3'(lfsr_reg[9:8]), 2'(lfsr_reg[11:10] % 3), 7'(lfsr_reg % 126),
            lfsr_reg[15:12], 0);
         d = {2'b01, lfsr_reg[13:0], lfsr_reg, lfsr_reg, lfsr_reg};
         id = {lfsr_reg[4], node_addr, 1'b1, lfsr_reg[6:5]};
         n = 4'h2 + 4'(lfsr_reg[1:0]) + 4'(lfsr_reg[3:2]);
         rx(id, n, 0, d, 2'b10);
         check({rx_short_reg, rx_dir_reg, rx_svc_reg, rx_len_reg, rx_class_reg, rx_frag_reg,
            rx_sel_reg, rx_param_reg[55:48]}, {1'b0, id[10], id[2:0], n, d[63:48]});
      end
      for (int v = 0; v < 8; v++) begin
         send(1, 3'(v), 2'h0, 7'(lfsr_reg % 126), lfsr_reg[3:0], 0);
      end
      send(0, 3'h7, 2'h2, 7'h7d, 4'hf, 0);
      send(0, 3'h4, 2'h0, 7'h00, 4'h1, 0);
      send(0, 3'h3, 2'h0, 7'h05, 4'h4, 1);
      send(0, 3'h5, 2'h3, 7'h05, 4'h4, 1);
      send(1, 3'h1, 2'h0, 7'h7e, 4'h0, 1);
      rx({1'b0, node_addr, 3'h5}, 0, 0, 0, 2'b10);
      check(state_reg, 1);
      take({1'b1, node_addr, 3'h7}, 0, 0);
      rx({1'b0, node_addr, 3'h4}, 0, 0, 0, 2'b10);
      check(state_reg, 0);
      take({1'b1, node_addr, 3'h6}, 0, 0);
      rx({1'b0, node_addr ^ 7'h01, 3'h5}, 0, 0, 0, 2'b00);
      rx({1'b0, node_addr, 3'h5}, 1, 0, 0, 2'b01);
      rx({1'b0, node_addr, 3'h5}, 9, 0, 0, 2'b01);
      rx({1'b0, node_addr, 3'h2}, 3, 0, 0, 2'b01);
      rx({1'b0, node_addr, 3'h5}, 3, 0, {2'b11, 62'h0}, 2'b01);
      rx({1'b0, node_addr, 3'h5}, 0, 1, 0, 2'b01);
      rx({1'b1, node_addr, 3'h5}, 0, 0, 0, 2'b10);
      check(state_reg, 0);
      for (int f = 0; f < 2; f++) begin
         rx({1'b0, node_addr, 3'h5}, 3, 0, 64'h0900_aa00_0000_0000, 2'b10);
         @(posedge clock);
         {ans_req, ans_fail, ans_code} <= {2'b10 | 2'(f), 8'h07};
         @(posedge clock);
         ans_req <= 1'b0;
         take({1'b1, node_addr, 3'h5}, 2, {f ? 16'h8907 : 16'h4900, 48'h0});
      end
      summarize();
   end
   // a full run needs a few hundred cycles; 30000 is about a hundred times that and means a hang
   initial begin
      repeat (30000) @(posedge clock);
      n_mismatch++;
      summarize();
   end
endmodule
